//--- fifo_status_defines.vh
// Register map, field positions and reset values for the FIFO status and send-length block
`ifndef FIFO_STATUS_DEFINES_VH
`define FIFO_STATUS_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Register addresses on the host register port
`define ADDR_W 5
`define ADDR_FIFO_OCCUPANCY_STATUS 5'h1C
`define ADDR_TX_LENGTH_UPPER 5'h1D
`define ADDR_TX_LENGTH_LOWER_PARTIAL 5'h1E

////////////////////////////////////////////////////////////////////////////////
// Storage and field layout
`define FIFO_CAPACITY 7'h7F
`define FILL_W 7
`define OVERFLOW_BIT 7
`define SEND_COUNT_W 12
`define PARTIAL_MSB 3
`define PARTIAL_LSB 1
`define PARTIAL_FLAG_BIT 0
`define NIBBLE_HI_MSB 7
`define NIBBLE_HI_LSB 4

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define TX_LENGTH_RESET 8'h00
`define FILL_RESET 7'h00
`define UNMAPPED_READ 8'h00

////////////////////////////////////////////////////////////////////////////////
// Synchroniser bundle: bit positions of the pins that cross into the clock domain
`define SYNC_W 17
`define SYNC_HOST_CLK 0
`define SYNC_SEL 1
`define SYNC_WR 2
`define SYNC_ADDR_LSB 3
`define SYNC_ADDR_MSB 7
`define SYNC_WDATA_LSB 8
`define SYNC_WDATA_MSB 15
`define SYNC_EN 16

`endif

//--- pin_sync.v
// Two-flip-flop synchroniser for a bundle of asynchronous pins
module pin_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Pins
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            reg meta_ff;
            reg stable_ff;
            always @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    meta_ff <= 1'b0;
                    stable_ff <= 1'b0;
                end else begin
                    meta_ff <= async_i[g];
                    stable_ff <= meta_ff;
                end
            end
            assign sync_o[g] = stable_ff;
        end
    endgenerate

endmodule

//--- word_buffer2.v
// Two-entry skid buffer with registered output, valid and ready on both sides
module word_buffer2 #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Filling side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // Draining side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);

    reg out_valid_ff;
    reg [WIDTH-1:0] out_data_ff;
    reg skid_valid_ff;
    reg [WIDTH-1:0] skid_data_ff;
    wire in_fire;
    wire out_free;

    // Second entry holds a word while the drain stalls, so none is lost
    assign in_ready_o = ~skid_valid_ff;
    assign in_fire = in_valid_i & ~skid_valid_ff;
    assign out_free = out_ready_i | ~out_valid_ff;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_valid_ff <= 1'b0;
            out_data_ff <= {WIDTH{1'b0}};
            skid_valid_ff <= 1'b0;
            skid_data_ff <= {WIDTH{1'b0}};
        end else if (out_free) begin
            if (skid_valid_ff) begin
                out_data_ff <= skid_data_ff;
                out_valid_ff <= 1'b1;
                skid_valid_ff <= 1'b0;
            end else begin
                out_valid_ff <= in_fire;
                if (in_fire) begin
                    out_data_ff <= in_data_i;
                end
            end
        end else if (in_fire) begin
            skid_data_ff <= in_data_i;
            skid_valid_ff <= 1'b1;
        end
    end

    assign out_valid_o = out_valid_ff;
    assign out_data_o = out_data_ff;

endmodule

//--- fifo_status_tx_length.v
// FIFO occupancy reporting and transmit-length registers behind the host register port
//
// Behaviour
// - Overflow flag in status bit 7 on excess push
// - Status low seven bits give fill count
// - Length registers zero at reset, enable low
// - Length registers cleared at end of frame
// - Count bits 11..4 fill first length register
// - Count bits 3..0 in second register high nibble
// - Second register bits 3..1 hold partial bits
// - Partial bits used only when flag set
// - Bit 0 set marks short final byte
`include "fifo_status_defines.vh"

module fifo_status_tx_length (
    // Clock and reset
    input wire REF_CLK_I,
    input wire RST_I,
    // Host register port pins, asynchronous to the reference clock
    input wire HOST_CLK_I,
    input wire HOST_SEL_I,
    input wire HOST_WR_I,
    input wire [`ADDR_W-1:0] HOST_ADDR_I,
    input wire [7:0] HOST_WDATA_I,
    // Chip enable pin
    input wire EN_I,
    // Read answers toward the host port serializer
    output wire RD_VALID_O,
    input wire RD_READY_I,
    output wire [7:0] RD_DATA_O,
    // FIFO events from the data path
    input wire PUSH_I,
    input wire POP_I,
    input wire FIFO_RESET_I,
    input wire TX_EOF_I,
    // State toward the encoder and the data path
    output wire [`FILL_W-1:0] FILL_COUNT_O,
    output wire OVERFLOW_O,
    output wire [`SEND_COUNT_W-1:0] SEND_COUNT_O,
    output wire PARTIAL_FLAG_O,
    output wire [2:0] PARTIAL_BITS_O
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and host clock edge detection

    wire [`SYNC_W-1:0] pin_bus;
    wire [`SYNC_W-1:0] pin_sync_q;
    wire host_clk_s;
    wire sel_s;
    wire wr_s;
    wire [`ADDR_W-1:0] addr_s;
    wire [7:0] wdata_s;
    wire en_s;
    reg host_clk_d_ff;
    wire host_edge;

    assign pin_bus = {EN_I, HOST_WDATA_I, HOST_ADDR_I, HOST_WR_I, HOST_SEL_I, HOST_CLK_I};

    // Clock and data pins share the same two-stage delay, so they stay aligned
    pin_sync #(
        .WIDTH(`SYNC_W)
    ) u_pin_sync (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .async_i(pin_bus),
        .sync_o(pin_sync_q)
    );

    assign host_clk_s = pin_sync_q[`SYNC_HOST_CLK];
    assign sel_s = pin_sync_q[`SYNC_SEL];
    assign wr_s = pin_sync_q[`SYNC_WR];
    assign addr_s = pin_sync_q[`SYNC_ADDR_MSB:`SYNC_ADDR_LSB];
    assign wdata_s = pin_sync_q[`SYNC_WDATA_MSB:`SYNC_WDATA_LSB];
    assign en_s = pin_sync_q[`SYNC_EN];

    always @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            host_clk_d_ff <= 1'b0;
        end else begin
            host_clk_d_ff <= host_clk_s;
        end
    end

    // Rising edge only; host clock idles low, so leaving reset gives no false edge
    assign host_edge = host_clk_s & ~host_clk_d_ff;

    wire wr_req;
    wire rd_req;
    assign wr_req = host_edge & sel_s & wr_s;
    assign rd_req = host_edge & sel_s & ~wr_s;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode

    wire hit_upper;
    wire hit_lower;
    wire wr_upper;
    wire wr_lower;

    assign hit_upper = (addr_s == `ADDR_TX_LENGTH_UPPER);
    assign hit_lower = (addr_s == `ADDR_TX_LENGTH_LOWER_PARTIAL);
    // No write strobe for the status address: it is read-only
    assign wr_upper = wr_req & hit_upper;
    assign wr_lower = wr_req & hit_lower;

    ////////////////////////////////////////////////////////////////////////////////
    // FIFO occupancy and overflow

    reg [`FILL_W-1:0] fill_ff;
    reg [`FILL_W-1:0] nxt_fill;
    reg overflow_ff;
    reg nxt_overflow;
    wire full;
    wire empty;
    wire push_ok;
    wire pop_ok;
    wire push_lost;

    assign full = (fill_ff == `FIFO_CAPACITY);
    assign empty = (fill_ff == `FILL_RESET);
    // A pop in the same cycle frees a slot, so a push onto a full FIFO is kept
    assign pop_ok = POP_I & ~empty;
    assign push_ok = PUSH_I & (~full | pop_ok);
    assign push_lost = PUSH_I & ~push_ok;

    always @* begin
        nxt_fill = fill_ff;
        nxt_overflow = overflow_ff;
        if (FIFO_RESET_I) begin
            nxt_fill = `FILL_RESET;
            nxt_overflow = 1'b0;
        end else if (push_ok & ~pop_ok) begin
            nxt_fill = fill_ff + 7'h01;
        end else if (pop_ok & ~push_ok) begin
            nxt_fill = fill_ff - 7'h01;
        end
        // Set wins over a FIFO reset in the same cycle; the excess byte is dropped
        if (push_lost) begin
            nxt_overflow = 1'b1;
        end
    end

    always @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            fill_ff <= `FILL_RESET;
            overflow_ff <= 1'b0;
        end else begin
            fill_ff <= nxt_fill;
            overflow_ff <= nxt_overflow;
        end
    end

    wire [7:0] status_word;
    assign status_word = {overflow_ff, fill_ff};

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit length registers

    reg [7:0] len_upper_ff;
    reg [7:0] len_lower_ff;
    reg [7:0] nxt_len_upper;
    reg [7:0] nxt_len_lower;

    always @* begin
        nxt_len_upper = len_upper_ff;
        nxt_len_lower = len_lower_ff;
        // A write in the closing cycle of a frame already belongs to the next one
        if (TX_EOF_I) begin
            nxt_len_upper = `TX_LENGTH_RESET;
            nxt_len_lower = `TX_LENGTH_RESET;
        end
        if (wr_upper) begin
            nxt_len_upper = wdata_s;
        end
        if (wr_lower) begin
            nxt_len_lower = wdata_s;
        end
        if (~en_s) begin
            nxt_len_upper = `TX_LENGTH_RESET;
            nxt_len_lower = `TX_LENGTH_RESET;
        end
    end

    always @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            len_upper_ff <= `TX_LENGTH_RESET;
            len_lower_ff <= `TX_LENGTH_RESET;
        end else begin
            len_upper_ff <= nxt_len_upper;
            len_lower_ff <= nxt_len_lower;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Decoded length toward the encoder, registered

    reg [`SEND_COUNT_W-1:0] send_count_ff;
    reg partial_flag_ff;
    reg [2:0] partial_bits_ff;
    wire nxt_partial_flag;
    wire [2:0] nxt_partial_bits;

    assign nxt_partial_flag = nxt_len_lower[`PARTIAL_FLAG_BIT];
    // Bit count is masked off for whole-byte frames
    assign nxt_partial_bits = nxt_partial_flag ?
        nxt_len_lower[`PARTIAL_MSB:`PARTIAL_LSB] : 3'h0;

    always @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            send_count_ff <= 12'h000;
            partial_flag_ff <= 1'b0;
            partial_bits_ff <= 3'h0;
        end else begin
            send_count_ff <= {nxt_len_upper,
                nxt_len_lower[`NIBBLE_HI_MSB:`NIBBLE_HI_LSB]};
            partial_flag_ff <= nxt_partial_flag;
            partial_bits_ff <= nxt_partial_bits;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register reads through the answer buffer

    localparam RD_IDLE = 1'b0;
    localparam RD_WAIT = 1'b1;

    reg rd_state_ff;
    reg nxt_rd_state;
    reg [7:0] rd_data_ff;
    reg [7:0] nxt_rd_data;
    reg [7:0] rd_mux;
    wire rd_pend;
    wire buf_in_ready;

    always @* begin
        case (addr_s)
            `ADDR_FIFO_OCCUPANCY_STATUS: rd_mux = status_word;
            `ADDR_TX_LENGTH_UPPER: rd_mux = len_upper_ff;
            `ADDR_TX_LENGTH_LOWER_PARTIAL: rd_mux = len_lower_ff;
            default: rd_mux = `UNMAPPED_READ;
        endcase
    end

    // Limitation: a read arriving while one still waits for buffer space is dropped
    always @* begin
        nxt_rd_state = rd_state_ff;
        nxt_rd_data = rd_data_ff;
        case (rd_state_ff)
            RD_IDLE: begin
                if (rd_req) begin
                    nxt_rd_state = RD_WAIT;
                    nxt_rd_data = rd_mux;
                end
            end
            RD_WAIT: begin
                if (buf_in_ready) begin
                    nxt_rd_state = RD_IDLE;
                end
            end
            default: begin
                nxt_rd_state = RD_IDLE;
            end
        endcase
    end

    always @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rd_state_ff <= RD_IDLE;
            rd_data_ff <= 8'h00;
        end else begin
            rd_state_ff <= nxt_rd_state;
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign rd_pend = (rd_state_ff == RD_WAIT);

    word_buffer2 #(
        .WIDTH(8)
    ) u_rd_buffer (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .in_valid_i(rd_pend),
        .in_ready_o(buf_in_ready),
        .in_data_i(rd_data_ff),
        .out_valid_o(RD_VALID_O),
        .out_ready_i(RD_READY_I),
        .out_data_o(RD_DATA_O)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign FILL_COUNT_O = fill_ff;
    assign OVERFLOW_O = overflow_ff;
    assign SEND_COUNT_O = send_count_ff;
    assign PARTIAL_FLAG_O = partial_flag_ff;
    assign PARTIAL_BITS_O = partial_bits_ff;

endmodule

//--- fifo_status_tx_length_properties.sv
// Concurrent checks for the FIFO status and send-length block
`include "fifo_status_defines.vh"
module fifo_status_checker (
    // Clock and reset
    input wire REF_CLK_I,
    input wire RST_I,
    // Pins and events
    input wire HOST_SEL_I,
    input wire EN_I,
    input wire RD_READY_I,
    input wire PUSH_I,
    input wire POP_I,
    input wire FIFO_RESET_I,
    input wire TX_EOF_I,
    // Block state
    input wire RD_VALID_O,
    input wire [7:0] RD_DATA_O,
    input wire [`FILL_W-1:0] FILL_COUNT_O,
    input wire OVERFLOW_O,
    input wire [`SEND_COUNT_W-1:0] SEND_COUNT_O,
    input wire PARTIAL_FLAG_O,
    input wire [2:0] PARTIAL_BITS_O
);
timeunit 1ns;
timeprecision 1ns;
default clocking @(posedge REF_CLK_I); endclocking
default disable iff (RST_I);
////////////////////////////////////////
property p_ovf_set;
    PUSH_I && !POP_I && !FIFO_RESET_I && FILL_COUNT_O == 7'h7F
        |=> OVERFLOW_O && FILL_COUNT_O == 7'h7F;
endproperty
a_ovf_set: assert property (p_ovf_set) else $error("overflow missed");
property p_ovf_hold;
    OVERFLOW_O && !FIFO_RESET_I |=> OVERFLOW_O;
endproperty
a_ovf_hold: assert property (p_ovf_hold) else $error("overflow lost");
property p_fill_inc;
    PUSH_I && !POP_I && !FIFO_RESET_I && FILL_COUNT_O < 7'h7F
        |=> FILL_COUNT_O == $past(FILL_COUNT_O) + 7'h01;
endproperty
a_fill_inc: assert property (p_fill_inc) else $error("push not counted");
property p_fill_dec;
    POP_I && !PUSH_I && !FIFO_RESET_I && FILL_COUNT_O != 7'h00
        |=> FILL_COUNT_O == $past(FILL_COUNT_O) - 7'h01;
endproperty
a_fill_dec: assert property (p_fill_dec) else $error("pop not counted");
// Five samples cover the two-stage synchroniser plus the clearing edge
property p_en_low;
    !EN_I [*5] |-> SEND_COUNT_O == 12'h000 && !PARTIAL_FLAG_O;
endproperty
a_en_low: assert property (p_en_low) else $error("length kept, enable low");
// Idle select keeps a host write from racing the clear
property p_eof;
    !HOST_SEL_I [*4] ##0 (TX_EOF_I && EN_I) |=> SEND_COUNT_O == 12'h000 && !PARTIAL_FLAG_O;
endproperty
a_eof: assert property (p_eof) else $error("length kept at frame end");
property p_bits_mask;
    !PARTIAL_FLAG_O |-> PARTIAL_BITS_O == 3'h0;
endproperty
a_bits_mask: assert property (p_bits_mask) else $error("partial bits leak");
property p_rd_hold;
    RD_VALID_O && !RD_READY_I |=> RD_VALID_O && $stable(RD_DATA_O);
endproperty
a_rd_hold: assert property (p_rd_hold) else $error("answer lost in stall");
c_ovf: cover property ($rose(OVERFLOW_O));
c_eof: cover property (TX_EOF_I && SEND_COUNT_O != 12'h000);
c_stall: cover property ((RD_VALID_O && !RD_READY_I) [*2]);
endmodule
bind fifo_status_tx_length fifo_status_checker u_chk (.REF_CLK_I, .RST_I, .HOST_SEL_I,
    .EN_I, .RD_READY_I, .PUSH_I, .POP_I, .FIFO_RESET_I, .TX_EOF_I, .RD_VALID_O, .RD_DATA_O,
    .FILL_COUNT_O, .OVERFLOW_O, .SEND_COUNT_O, .PARTIAL_FLAG_O, .PARTIAL_BITS_O);

//--- host_model.sv
// Host microcontroller model driving the register port pins
module host_model (
    input wire logic clk_i,
    output logic host_clk_o = 1'b0,
    output logic sel_o = 1'b0,
    output logic wr_o = 1'b0,
    output logic [4:0] addr_o = 5'h00,
    output logic [7:0] wdata_o = 8'h00
);
timeunit 1ns;
timeprecision 1ns;
// One access per 160 ns host clock period, clock idle low between accesses
task access(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #2;
    sel_o = 1'b1;
    wr_o = w;
    addr_o = a;
    wdata_o = d;
    #80 host_clk_o = 1'b1;
    #80 host_clk_o = 1'b0;
    // Inverted on release so a stale value never passes for a good one
    #80 sel_o = 1'b0;
    wr_o = ~w;
    addr_o = ~a;
    wdata_o = ~d;
endtask
endmodule

//--- tb_fifo_status_tx_length.sv
// Self-checking bench for the FIFO status and send-length block
`include "fifo_status_defines.vh"
module tb_fifo_status_tx_length;
timeunit 1ns;
timeprecision 1ns;
localparam logic [11:0] CNT = 12'hABC;
logic REF_CLK_I = 0, RST_I = 1, EN_I = 1, RD_READY_I = 0;
logic PUSH_I = 0, POP_I = 0, FIFO_RESET_I = 0, TX_EOF_I = 0;
logic HOST_CLK_I, HOST_SEL_I, HOST_WR_I, RD_VALID_O, OVERFLOW_O, PARTIAL_FLAG_O;
logic [4:0] HOST_ADDR_I;
logic [7:0] HOST_WDATA_I, RD_DATA_O;
logic [6:0] FILL_COUNT_O;
logic [11:0] SEND_COUNT_O;
logic [2:0] PARTIAL_BITS_O;
int num_errors = 0;
int check_count = 0;
fifo_status_tx_length u_dut (.REF_CLK_I, .RST_I, .HOST_CLK_I, .HOST_SEL_I, .HOST_WR_I,
    .HOST_ADDR_I, .HOST_WDATA_I, .EN_I, .RD_VALID_O, .RD_READY_I, .RD_DATA_O, .PUSH_I,
    .POP_I, .FIFO_RESET_I, .TX_EOF_I, .FILL_COUNT_O, .OVERFLOW_O, .SEND_COUNT_O,
    .PARTIAL_FLAG_O, .PARTIAL_BITS_O);
host_model u_host (.clk_i(REF_CLK_I), .host_clk_o(HOST_CLK_I), .sel_o(HOST_SEL_I),
    .wr_o(HOST_WR_I), .addr_o(HOST_ADDR_I), .wdata_o(HOST_WDATA_I));
initial forever #10 REF_CLK_I = ~REF_CLK_I;
////////////////////////////////////////
task chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
        num_errors++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task stop_test;
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
endtask
task wr(input logic [4:0] a, input logic [7:0] d);
    u_host.access(1'b1, a, d);
endtask
task rq(input logic [4:0] a);
    u_host.access(1'b0, a, 8'h00);
endtask
// Ready stays low until checked, so each answer must wait in the buffer
task take(input logic [7:0] e);
    int n;
    n = 0;
    while (RD_VALID_O !== 1'b1 && n < 40) begin
        @(negedge REF_CLK_I);
        n++;
    end
    chk(RD_VALID_O, 1'b1);
    chk(RD_DATA_O, e);
    @(posedge REF_CLK_I) #2 RD_READY_I = 1;
    @(posedge REF_CLK_I) #2 RD_READY_I = 0;
endtask
task rd(input logic [4:0] a, input logic [7:0] e);
    rq(a);
    take(e);
endtask
task ev(input logic p, input logic q, input int n);
    @(posedge REF_CLK_I) #2 {PUSH_I, POP_I} = {p, q};
    repeat (n) @(posedge REF_CLK_I);
    #2 {PUSH_I, POP_I} = 2'b00;
endtask
////////////////////////////////////////
task t_reset;
    ev(0, 1, 1);
    chk(FILL_COUNT_O, 0);
    chk(OVERFLOW_O, 0);
    rd(`ADDR_TX_LENGTH_UPPER, 8'h00);
    rd(`ADDR_TX_LENGTH_LOWER_PARTIAL, 8'h00);
    wr(`ADDR_FIFO_OCCUPANCY_STATUS, 8'h55);
    rd(`ADDR_FIFO_OCCUPANCY_STATUS, 8'h00);
    rd(5'h05, `UNMAPPED_READ);
endtask
task t_len;
    wr(`ADDR_TX_LENGTH_UPPER, CNT[11:4]);
    wr(`ADDR_TX_LENGTH_LOWER_PARTIAL, {CNT[3:0], 3'h3, 1'b1});
    chk(SEND_COUNT_O, CNT);
    chk(PARTIAL_FLAG_O, 1);
    chk(PARTIAL_BITS_O, 3);
    rq(`ADDR_TX_LENGTH_UPPER);
    rq(`ADDR_TX_LENGTH_LOWER_PARTIAL);
    take(CNT[11:4]);
    take({CNT[3:0], 4'h7});
    wr(`ADDR_TX_LENGTH_LOWER_PARTIAL, {CNT[3:0], 4'h6});
    chk(PARTIAL_FLAG_O, 0);
    chk(PARTIAL_BITS_O, 0);
    rd(`ADDR_TX_LENGTH_LOWER_PARTIAL, {CNT[3:0], 4'h6});
endtask
task t_eof;
    repeat (4) @(posedge REF_CLK_I);
    #2 TX_EOF_I = 1;
    @(posedge REF_CLK_I) #2 TX_EOF_I = 0;
    chk(SEND_COUNT_O, 0);
    rd(`ADDR_TX_LENGTH_LOWER_PARTIAL, 8'h00);
endtask
task t_en;
    wr(`ADDR_TX_LENGTH_UPPER, 8'h12);
    @(posedge REF_CLK_I) #2 EN_I = 0;
    repeat (4) @(posedge REF_CLK_I);
    #2 chk(SEND_COUNT_O, 0);
    wr(`ADDR_TX_LENGTH_UPPER, 8'h34);
    chk(SEND_COUNT_O, 0);
    @(posedge REF_CLK_I) #2 EN_I = 1;
    repeat (4) @(posedge REF_CLK_I);
    rd(`ADDR_TX_LENGTH_UPPER, 8'h00);
endtask
task t_fill;
    ev(1, 0, 3);
    ev(0, 1, 1);
    rd(`ADDR_FIFO_OCCUPANCY_STATUS, 8'h02);
    ev(1, 1, 2);
    chk(FILL_COUNT_O, 2);
    ev(1, 0, 125);
    chk({OVERFLOW_O, FILL_COUNT_O}, 8'h7F);
    ev(1, 0, 1);
    chk({OVERFLOW_O, FILL_COUNT_O}, 8'hFF);
    rd(`ADDR_FIFO_OCCUPANCY_STATUS, 8'hFF);
    ev(1, 1, 1);
    chk(FILL_COUNT_O, 8'h7F);
    ev(0, 1, 1);
    chk({OVERFLOW_O, FILL_COUNT_O}, 8'hFE);
    @(posedge REF_CLK_I) #2 FIFO_RESET_I = 1;
    @(posedge REF_CLK_I) #2 FIFO_RESET_I = 0;
    chk(OVERFLOW_O, 0);
endtask
// Device reset in mid-run clears lengths and occupancy that were set before
task t_rst;
    wr(`ADDR_TX_LENGTH_UPPER, 8'h5A);
    ev(1, 0, 2);
    chk(SEND_COUNT_O, 12'h5A0);
    chk(FILL_COUNT_O, 2);
    @(posedge REF_CLK_I) #2 RST_I = 1;
    @(posedge REF_CLK_I) #2 RST_I = 0;
    chk({OVERFLOW_O, FILL_COUNT_O}, 8'h00);
    chk(SEND_COUNT_O, 0);
    repeat (4) @(posedge REF_CLK_I);
    rd(`ADDR_TX_LENGTH_UPPER, 8'h00);
endtask
initial begin
    #200000;
    num_errors++;
    stop_test;
end
initial begin
    repeat (2) @(posedge REF_CLK_I);
    #2 RST_I = 0;
    t_reset;
    t_len;
    t_eof;
    t_en;
    t_fill;
    t_rst;
    stop_test;
end
endmodule
